// >>> rtl/mcas_map.svh
`ifndef MCAS_MAP_SVH
`define MCAS_MAP_SVH
// device register map
`define MCAS_TUNING_CTL 8'h12
`define MCAS_CAL_STATUS 8'h13
`define MCAS_TUNING_RST 8'h00
`define MCAS_START_BIT 0
// clock rate and millisecond divider
`define MCAS_CLK_MHZ 200
`define MCAS_KHZ_PER_MHZ 1000
// sequence timeline in ms
`define MCAS_TONE1_START_LIMIT 10'd10
`define MCAS_TONE1_END_LIMIT 10'd200
`define MCAS_TONE2_START_LIMIT 10'd210
`define MCAS_TONE2_END_LIMIT 10'd400
`define MCAS_TONE3_START_LIMIT 10'd410
`define MCAS_TONE3_END_LIMIT 10'd600
`define MCAS_SEQUENCE_COMPLETE_TIME 10'd790
// host stimulus segment and settle step in ms
`define MCAS_SEG_MS 10'd201
`define MCAS_STEP_MS 10'd1
// host axi register map
`define MCAS_H_CTRL 4'h0
`define MCAS_H_STAT 4'h4
`define MCAS_H_HOLD 4'h8
`define MCAS_CTRL_GO 0
`define MCAS_CTRL_USE_REG 1
`define MCAS_CTRL_COMMIT 2
`define MCAS_CTRL_THREE 3
`define MCAS_RESP_OK 2'h0
`define MCAS_RESP_ERR 2'h2
`endif

// >>> rtl/mcas_pkg.sv
package mcas_pkg;
   typedef enum logic [1:0] {
      MCAS_SILENT, MCAS_TONE_1K, MCAS_TONE_300, MCAS_TONE_3K
   } mcas_tone_e;
   typedef enum logic [1:0] {DEV_IDLE, DEV_RUN, DEV_HELD} mcas_dev_e;
   typedef enum logic [2:0] {
      H_IDLE, H_WE_UP, H_HOLD, H_STOP, H_RDSTAT, H_WAIT_ACK
   } mcas_host_e;
endpackage

// >>> rtl/mcas_if.sv
`timescale 1ns/10ps
interface mcas_if;
   logic cal_trigger;
   logic nvm_write_enable;
   mcas_pkg::mcas_tone_e mic_tone;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic reg_ack;
   modport device (
      input cal_trigger, nvm_write_enable, mic_tone,
      input reg_wr, reg_rd, reg_addr, reg_wdata,
      output reg_rdata, reg_ack
   );
   modport host (
      output cal_trigger, nvm_write_enable, mic_tone,
      output reg_wr, reg_rd, reg_addr, reg_wdata,
      input reg_rdata, reg_ack
   );
endinterface

// >>> rtl/mcas_ms_tick.sv
`timescale 1ns/10ps
// one-cycle enable every CYCLES clocks; restart realigns the phase
module mcas_ms_tick #(
   parameter int unsigned CYCLES = 200000
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic restart,
   output logic tick
);
   localparam int W = $clog2(CYCLES + 1);
   logic [W-1:0] cnt;
   wire last = (cnt == W'(CYCLES - 1));
   wire [W-1:0] next_cnt = (restart || last) ? '0 : cnt + W'(1);
   // divider count and its pulse
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '0;
         tick <= 1'b0;
      end else begin
         cnt <= next_cnt;
         tick <= last && !restart;
      end
   end
endmodule // mcas_ms_tick

// >>> rtl/mcas_device.sv
`timescale 1ns/10ps
`include "mcas_map.svh"
module mcas_device #(
   parameter int unsigned CYCLES_PER_MS = `MCAS_CLK_MHZ * `MCAS_KHZ_PER_MHZ
) (
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   mcas_if.device LINK,
   output logic CAL_BUSY,
   output logic COEF_STROBE,
   output logic NVM_COMMIT,
   output logic THREE_TONE,
   output logic [2:0] TONES_SEEN
);
   ////////////////////////////////////////////////////////////////////////
   // window test, used for all three tones
   function automatic logic in_win(input logic [9:0] t,
                                   input logic [9:0] lo,
                                   input logic [9:0] hi);
      in_win = (t >= lo) && (t < hi);
   endfunction

   mcas_pkg::mcas_dev_e state;
   mcas_pkg::mcas_dev_e next_state;
   logic [2:0] trig_sync;
   logic [2:0] nve_sync;
   logic trig_lvl;
   logic nve_lvl;
   logic [7:0] tuning_ctl;
   logic src_reg;
   logic we_ok;
   logic done;
   logic stored_nvm;
   logic [9:0] ms;
   logic tick;
   logic restart;

   ////////////////////////////////////////////////////////////////////////
   // pin levels: three flops, change accepted when last two agree
   wire trig_agree = (trig_sync[2] == trig_sync[1]);
   wire nve_agree = (nve_sync[2] == nve_sync[1]);
   wire trig_rise = trig_agree && trig_sync[1] && !trig_lvl;
   wire trig_fall = trig_agree && !trig_sync[1] && trig_lvl;
   wire next_trig_lvl = trig_agree ? trig_sync[1] : trig_lvl;
   wire next_nve_lvl = nve_agree ? nve_sync[1] : nve_lvl;

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         trig_sync <= 3'h0;
         nve_sync <= 3'h0;
         trig_lvl <= 1'b0;
         nve_lvl <= 1'b0;
      end else begin
         trig_sync <= {trig_sync[1:0], LINK.cal_trigger};
         nve_sync <= {nve_sync[1:0], LINK.nvm_write_enable};
         trig_lvl <= next_trig_lvl;
         nve_lvl <= next_nve_lvl;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register port decode
   wire reg_start = tuning_ctl[`MCAS_START_BIT];
   wire ctl_hit = (LINK.reg_addr == `MCAS_TUNING_CTL);
   wire stat_hit = (LINK.reg_addr == `MCAS_CAL_STATUS);
   wire ctl_wr = LINK.reg_wr && ctl_hit;
   wire wr_start = LINK.reg_wdata[`MCAS_START_BIT];
   wire reg_set = ctl_wr && wr_start && !reg_start;
   wire reg_clr = ctl_wr && !wr_start && reg_start;
   wire [7:0] status_val = {2'h0, TONES_SEEN, stored_nvm, done, CAL_BUSY};
   wire [7:0] next_rdata = ctl_hit ? tuning_ctl :
                           stat_hit ? status_val : 8'h00;

   // start bit is plain storage; its edges are what steer the engine
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         tuning_ctl <= `MCAS_TUNING_RST;
         LINK.reg_rdata <= 8'h00;
         LINK.reg_ack <= 1'b0;
      end else begin
         if (ctl_wr) begin
            tuning_ctl <= LINK.reg_wdata;
         end
         if (LINK.reg_rd) begin
            LINK.reg_rdata <= next_rdata;
         end
         LINK.reg_ack <= LINK.reg_wr || LINK.reg_rd;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // start and stop events
   // a set bit masks pin rises so both paths never fight for one run
   wire pin_start = trig_rise && !reg_start;
   wire start_ev = (state == mcas_pkg::DEV_IDLE) &&
                   (reg_set || pin_start);
   wire stop_ev = src_reg ? reg_clr : trig_fall;
   wire complete = (state == mcas_pkg::DEV_RUN) && tick &&
                   (ms == `MCAS_SEQUENCE_COMPLETE_TIME - 10'd1);

   // next state: a stop before completion aborts with nothing stored
   always_comb begin
      next_state = state;
      case (state)
         mcas_pkg::DEV_IDLE: begin
            if (start_ev) begin
               next_state = mcas_pkg::DEV_RUN;
            end
         end
         mcas_pkg::DEV_RUN: begin
            if (stop_ev) begin
               next_state = mcas_pkg::DEV_IDLE;
            end else if (complete) begin
               next_state = mcas_pkg::DEV_HELD;
            end
         end
         mcas_pkg::DEV_HELD: begin
            if (stop_ev) begin
               next_state = mcas_pkg::DEV_IDLE;
            end
         end
         default: begin
            next_state = mcas_pkg::DEV_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // millisecond time base, realigned at every accepted start
   assign restart = start_ev;

   mcas_ms_tick #(
      .CYCLES(CYCLES_PER_MS)
   ) u_tick (
      .clk(SYS_CLK),
      .rst_n(RESET_N),
      .restart(restart),
      .tick(tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // tone evaluation windows; samples outside them are dropped
   wire running = (state == mcas_pkg::DEV_RUN);
   wire win1 = in_win(ms, `MCAS_TONE1_START_LIMIT,
                      `MCAS_TONE1_END_LIMIT);
   wire win2 = in_win(ms, `MCAS_TONE2_START_LIMIT,
                      `MCAS_TONE2_END_LIMIT);
   wire win3 = in_win(ms, `MCAS_TONE3_START_LIMIT,
                      `MCAS_TONE3_END_LIMIT);
   wire hit1 = win1 && (LINK.mic_tone == mcas_pkg::MCAS_TONE_1K);
   wire hit2 = win2 && (LINK.mic_tone == mcas_pkg::MCAS_TONE_300);
   wire hit3 = win3 && (LINK.mic_tone == mcas_pkg::MCAS_TONE_3K);
   // gaps between windows give no hit at all
   wire [2:0] hits = (running && tick) ?
                     {hit3, hit2, hit1} : 3'h0;
   wire [2:0] next_seen = start_ev ? 3'h0 : (TONES_SEEN | hits);
   wire all_three = &next_seen;
   wire next_we_ok = start_ev ? next_nve_lvl :
                     (we_ok && (!running || next_nve_lvl));

   ////////////////////////////////////////////////////////////////////////
   // sequence state, time and coefficient store strobes
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state <= mcas_pkg::DEV_IDLE;
         ms <= 10'h000;
         src_reg <= 1'b0;
         we_ok <= 1'b0;
         TONES_SEEN <= 3'h0;
         CAL_BUSY <= 1'b0;
         done <= 1'b0;
         stored_nvm <= 1'b0;
         COEF_STROBE <= 1'b0;
         NVM_COMMIT <= 1'b0;
         THREE_TONE <= 1'b0;
      end else begin
         state <= next_state;
         // busy also marks the raised supply draw of the engine
         CAL_BUSY <= (next_state != mcas_pkg::DEV_IDLE);
         if (start_ev) begin
            ms <= 10'h000;
            src_reg <= reg_set;
            done <= 1'b0;
            stored_nvm <= 1'b0;
         end else if (running && tick) begin
            ms <= ms + 10'd1;
         end
         we_ok <= next_we_ok;
         TONES_SEEN <= next_seen;
         // working set is always updated, eeprom only when allowed
         COEF_STROBE <= complete && !stop_ev;
         NVM_COMMIT <= complete && !stop_ev && next_we_ok;
         if (complete && !stop_ev) begin
            done <= 1'b1;
            stored_nvm <= next_we_ok;
            THREE_TONE <= all_three;
         end
      end
   end
endmodule // mcas_device

// >>> rtl/mcas_host.sv
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "mcas_map.svh"
module mcas_host #(
   parameter int unsigned CYCLES_PER_MS = `MCAS_CLK_MHZ * `MCAS_KHZ_PER_MHZ
) (
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   input wire logic [3:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [3:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   mcas_if.host LINK
);
   mcas_pkg::mcas_host_e st;
   logic [3:0] ctrl;
   logic [9:0] hold_ms;
   logic [7:0] dev_stat;
   logic done;
   logic aw_full;
   logic w_full;
   logic [3:0] aw_addr;
   logic [31:0] w_data;
   logic w_lane0;
   logic [9:0] ms;
   logic tick;
   logic restart;

   ////////////////////////////////////////////////////////////////////////
   // axi write path: address and data taken in either order
   wire aw_take = AWVALID && AWREADY;
   wire w_take = WVALID && WREADY;
   wire wr_do = aw_full && w_full && !BVALID;
   wire next_aw_full = (aw_full && !wr_do) || aw_take;
   wire next_w_full = (w_full && !wr_do) || w_take;
   wire hit_ctrl = (aw_addr == `MCAS_H_CTRL);
   wire hit_hold = (aw_addr == `MCAS_H_HOLD);
   wire hit_stat = (aw_addr == `MCAS_H_STAT);
   wire wr_ok = hit_ctrl || hit_hold || hit_stat;
   wire go = wr_do && hit_ctrl && w_lane0 && w_data[`MCAS_CTRL_GO] &&
             (st == mcas_pkg::H_IDLE);
   // read path
   wire ar_take = ARVALID && ARREADY;
   wire next_rvalid = (RVALID && !RREADY) || ar_take;
   wire [31:0] stat_val = {16'h0000, dev_stat, 6'h00, done,
                           (st != mcas_pkg::H_IDLE)};
   wire [31:0] rd_val = (ARADDR == `MCAS_H_CTRL) ? {28'h0, ctrl} :
                        (ARADDR == `MCAS_H_HOLD) ? {22'h0, hold_ms} :
                        stat_val;
   wire rd_ok = (ARADDR == `MCAS_H_CTRL) || (ARADDR == `MCAS_H_HOLD) ||
                (ARADDR == `MCAS_H_STAT);

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         AWREADY <= 1'b1;
         WREADY <= 1'b1;
         aw_addr <= 4'h0;
         w_data <= 32'h0000_0000;
         w_lane0 <= 1'b0;
         BVALID <= 1'b0;
         BRESP <= `MCAS_RESP_OK;
         ARREADY <= 1'b1;
         RVALID <= 1'b0;
         RDATA <= 32'h0000_0000;
         RRESP <= `MCAS_RESP_OK;
      end else begin
         aw_full <= next_aw_full;
         w_full <= next_w_full;
         AWREADY <= !next_aw_full;
         WREADY <= !next_w_full;
         if (aw_take) begin
            aw_addr <= AWADDR;
         end
         if (w_take) begin
            w_data <= WDATA;
            w_lane0 <= WSTRB[0];
         end
         if (wr_do) begin
            BVALID <= 1'b1;
            BRESP <= wr_ok ? `MCAS_RESP_OK : `MCAS_RESP_ERR;
         end else if (BREADY) begin
            BVALID <= 1'b0;
         end
         RVALID <= next_rvalid;
         ARREADY <= !next_rvalid;
         if (ar_take) begin
            RDATA <= rd_ok ? rd_val : 32'h0000_0000;
            RRESP <= rd_ok ? `MCAS_RESP_OK : `MCAS_RESP_ERR;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // millisecond base, realigned at each step of the sequence
   mcas_ms_tick #(
      .CYCLES(CYCLES_PER_MS)
   ) u_tick (
      .clk(SYS_CLK),
      .rst_n(RESET_N),
      .restart(restart),
      .tick(tick)
   );

   // too short a hold is stretched past the full timeline; one step of
   // margin keeps the stop out of the device's completion cycle
   wire [9:0] hold_min = `MCAS_SEQUENCE_COMPLETE_TIME + `MCAS_STEP_MS;
   wire [9:0] hold_eff = (hold_ms < hold_min) ? hold_min : hold_ms;
   wire use_reg = ctrl[`MCAS_CTRL_USE_REG];
   wire three = ctrl[`MCAS_CTRL_THREE];
   wire step_end = tick && (ms == `MCAS_STEP_MS - 10'd1);
   wire hold_end = tick && (ms == hold_eff - 10'd1);
   wire seg1 = ms < `MCAS_SEG_MS;
   wire seg2 = ms < (`MCAS_SEG_MS + `MCAS_SEG_MS);
   wire seg3 = ms < (`MCAS_SEG_MS + `MCAS_SEG_MS + `MCAS_SEG_MS);
   // stimulus follows the fixed tone order when three is set, 1K throughout otherwise; silent after the last
   wire mcas_pkg::mcas_tone_e tone_sel =
      !seg3 ? mcas_pkg::MCAS_SILENT :
      (!three || seg1) ? mcas_pkg::MCAS_TONE_1K :
      seg2 ? mcas_pkg::MCAS_TONE_300 : mcas_pkg::MCAS_TONE_3K;
   assign restart = go || (st == mcas_pkg::H_WE_UP && step_end) ||
                    (st == mcas_pkg::H_HOLD && hold_end);

   ////////////////////////////////////////////////////////////////////////
   // calibration sequencer toward the device
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         st <= mcas_pkg::H_IDLE;
         ctrl <= 4'h0;
         hold_ms <= `MCAS_SEQUENCE_COMPLETE_TIME;
         dev_stat <= 8'h00;
         done <= 1'b0;
         ms <= 10'h000;
         LINK.cal_trigger <= 1'b0;
         LINK.nvm_write_enable <= 1'b0;
         LINK.mic_tone <= mcas_pkg::MCAS_SILENT;
         LINK.reg_wr <= 1'b0;
         LINK.reg_rd <= 1'b0;
         LINK.reg_addr <= 8'h00;
         LINK.reg_wdata <= 8'h00;
      end else begin
         LINK.reg_wr <= 1'b0;
         LINK.reg_rd <= 1'b0;
         if (wr_do && w_lane0 && hit_ctrl && st == mcas_pkg::H_IDLE) begin
            ctrl <= {w_data[3:1], 1'b0};
         end
         if (wr_do && hit_hold && st == mcas_pkg::H_IDLE) begin
            hold_ms <= w_data[9:0];
         end
         if (restart) begin
            ms <= 10'h000;
         end else if (tick) begin
            ms <= ms + 10'd1;
         end
         case (st)
            mcas_pkg::H_IDLE: begin
               if (go) begin
                  // enable rises first, trigger a step later
                  LINK.nvm_write_enable <= w_data[`MCAS_CTRL_COMMIT];
                  ctrl <= {w_data[3:1], 1'b0};
                  done <= 1'b0;
                  st <= mcas_pkg::H_WE_UP;
               end
            end
            mcas_pkg::H_WE_UP: begin
               if (step_end) begin
                  LINK.cal_trigger <= !use_reg;
                  LINK.reg_wr <= use_reg;
                  LINK.reg_addr <= `MCAS_TUNING_CTL;
                  LINK.reg_wdata <= 8'h01;
                  st <= mcas_pkg::H_HOLD;
               end
            end
            mcas_pkg::H_HOLD: begin
               LINK.mic_tone <= tone_sel;
               if (hold_end) begin
                  LINK.mic_tone <= mcas_pkg::MCAS_SILENT;
                  LINK.cal_trigger <= 1'b0;
                  LINK.reg_wr <= use_reg;
                  LINK.reg_wdata <= 8'h00;
                  st <= mcas_pkg::H_STOP;
               end
            end
            mcas_pkg::H_STOP: begin
               if (step_end) begin
                  LINK.nvm_write_enable <= 1'b0;
                  st <= mcas_pkg::H_RDSTAT;
               end
            end
            mcas_pkg::H_RDSTAT: begin
               LINK.reg_rd <= 1'b1;
               LINK.reg_addr <= `MCAS_CAL_STATUS;
               st <= mcas_pkg::H_WAIT_ACK;
            end
            mcas_pkg::H_WAIT_ACK: begin
               if (LINK.reg_ack) begin
                  dev_stat <= LINK.reg_rdata;
                  done <= 1'b1;
                  st <= mcas_pkg::H_IDLE;
               end
            end
            default: begin
               st <= mcas_pkg::H_IDLE;
            end
         endcase
      end
   end
endmodule // mcas_host

// >>> sim/mcas_checker.sv
`timescale 1ns/10ps
`include "mcas_map.svh"
module mcas_checker #(
   parameter int unsigned CYCLES_PER_MS = 4
) (
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   input wire logic cal_trigger,
   input wire logic nvm_write_enable,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_ack,
   input wire logic CAL_BUSY,
   input wire logic COEF_STROBE,
   input wire logic NVM_COMMIT
);
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RESET_N);
   localparam int unsigned SEQUENCE_COMPLETE_TIME = `MCAS_SEQUENCE_COMPLETE_TIME * CYCLES_PER_MS;
   logic start_bit;
   logic [31:0] hi_cnt;
   logic [31:0] busy_cnt;
   wire ctl_wr = reg_wr && (reg_addr == `MCAS_TUNING_CTL);
   ////////////////////////////////////////
   // shadow start bit; counters give the hold and run lengths
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         start_bit <= 1'b0;
         hi_cnt <= 32'h0;
         busy_cnt <= 32'h0;
      end else begin
         if (ctl_wr) start_bit <= reg_wdata[0];
         hi_cnt <= cal_trigger ? hi_cnt + 32'h1 : 32'h0;
         busy_cnt <= CAL_BUSY ? busy_cnt + 32'h1 : 32'h0;
      end
   end
   ////////////////////////////////////////
   AST_WE_LEADS: assert property ($rose(cal_trigger) |->
      $stable(nvm_write_enable)) else $error("enable moved with trigger");
   AST_WE_TRAILS: assert property ($fell(nvm_write_enable) |->
      !cal_trigger && !start_bit) else $error("enable dropped early");
   AST_TRIG_HOLD: assert property ($fell(cal_trigger) |->
      hi_cnt >= SEQUENCE_COMPLETE_TIME - CYCLES_PER_MS) else $error("trigger hold short");
   AST_TRIG_START: assert property ($rose(cal_trigger) && !start_bit
      && !CAL_BUSY |-> ##[2:6] CAL_BUSY) else $error("pin start missed");
   AST_TRIG_STOP: assert property ($fell(cal_trigger) |->
      ##[1:6] !CAL_BUSY) else $error("pin stop missed");
   AST_REG_START: assert property (ctl_wr && reg_wdata[0] &&
      !start_bit && !CAL_BUSY && !cal_trigger |-> ##[1:3] CAL_BUSY)
      else $error("register start missed");
   AST_REG_HOLD: assert property (CAL_BUSY && start_bit && !ctl_wr
      |=> CAL_BUSY) else $error("register run ended while bit set");
   AST_COMMIT: assert property (NVM_COMMIT |-> COEF_STROBE)
      else $error("commit without completion");
   AST_VOLATILE: assert property (COEF_STROBE |->
      NVM_COMMIT == nvm_write_enable) else $error("commit vs enable");
   AST_COMPLETE: assert property (COEF_STROBE |->
      busy_cnt >= SEQUENCE_COMPLETE_TIME - 2 && busy_cnt <= SEQUENCE_COMPLETE_TIME + CYCLES_PER_MS)
      else $error("completion time off");
   AST_ACK: assert property (reg_wr || reg_rd |=> reg_ack)
      else $error("register access not acked");
   AST_ACK_CAUSE: assert property (reg_ack |-> $past(reg_wr) ||
      $past(reg_rd)) else $error("spurious ack");
   // main scenarios reached
   cover property (NVM_COMMIT);
   cover property (COEF_STROBE && !NVM_COMMIT);
   cover property ($rose(CAL_BUSY) && start_bit);
endmodule // mcas_checker

// >>> sim/testbench.sv
`timescale 1ns/10ps
`include "mcas_map.svh"
module testbench;
   localparam int unsigned CPM = 4;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] awaddr = 4'h0;
   logic awvalid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic [3:0] araddr = 4'h0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, d;
   logic cal_busy, coef_strobe, nvm_commit, three_tone;
   logic [2:0] tones_seen;
   int error_cnt = 0;
   int num_checks = 0;
   int n_strobe = 0;
   int n_commit = 0;
   int unsigned hold_ms = 790;
   logic [31:0] r;
   mcas_if link ();
   mcas_host #(.CYCLES_PER_MS(CPM)) mcas_host_i (.SYS_CLK(sys_clk),
      .RESET_N(reset_n), .AWADDR(awaddr), .AWVALID(awvalid),
      .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
      .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
      .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
      .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
      .LINK(link));
   mcas_device #(.CYCLES_PER_MS(CPM)) mcas_device_i (.SYS_CLK(sys_clk),
      .RESET_N(reset_n), .LINK(link), .CAL_BUSY(cal_busy),
      .COEF_STROBE(coef_strobe), .NVM_COMMIT(nvm_commit),
      .THREE_TONE(three_tone), .TONES_SEEN(tones_seen));
   mcas_checker #(.CYCLES_PER_MS(CPM)) mcas_checker_i (.SYS_CLK(sys_clk),
      .RESET_N(reset_n), .cal_trigger(link.cal_trigger),
      .nvm_write_enable(link.nvm_write_enable), .reg_wr(link.reg_wr),
      .reg_rd(link.reg_rd), .reg_addr(link.reg_addr),
      .reg_wdata(link.reg_wdata), .reg_ack(link.reg_ack),
      .CAL_BUSY(cal_busy), .COEF_STROBE(coef_strobe),
      .NVM_COMMIT(nvm_commit));
   ////////////////////////////////////////
   // free-running clock; pulses are counted at the edge after they show
   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (coef_strobe === 1'b1) n_strobe++;
      if (nvm_commit === 1'b1) n_commit++;
   end
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: %s got %0h exp %0h", $time, what,
                  got, exp);
      end
   endtask
   // write offers address and data together, each dropped once taken
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] v,
                         input logic [1:0] er);
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // no cycle count assumed: waits for bvalid, bounded only by the watchdog
      do begin
         @(posedge sys_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      chk({31'h0, bvalid}, 32'h1, "bvalid");
      chk({30'h0, bresp}, {30'h0, er}, "bresp");
      bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] v,
                         input logic [1:0] er);
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      chk({31'h0, rvalid}, 32'h1, "rvalid");
      chk({30'h0, rresp}, {30'h0, er}, "rresp");
      v = rdata;
      rready <= 1'b0;
   endtask
   function automatic logic [2:0] exp_tones(input logic three);
      return three ? 3'h7 : 3'h1;
   endfunction
   ////////////////////////////////////////
   // one full calibration; polling is bounded so a hang cannot stall
   task automatic run(input logic use_reg, input logic commit,
                      input logic three);
      int s0;
      int c0;
      int n;
      logic [31:0] v;
      s0 = n_strobe;
      c0 = n_commit;
      axi_wr(`MCAS_H_CTRL, {28'h0, three, commit, use_reg, 1'b1},
             `MCAS_RESP_OK);
      axi_wr(`MCAS_H_HOLD, 32'h3E8, `MCAS_RESP_OK);
      axi_rd(`MCAS_H_HOLD, v, `MCAS_RESP_OK);
      chk(v, hold_ms, "hold kept while busy");
      for (n = 0; n < 600; n++) begin
         repeat (10) @(posedge sys_clk);
         axi_rd(`MCAS_H_STAT, v, `MCAS_RESP_OK);
         if (v[1:0] === 2'h2) break;
      end
      chk({30'h0, v[1:0]}, 32'h2, "done not busy");
      chk({31'h0, cal_busy}, 32'h0, "engine off");
      chk(n_strobe - s0, 32'h1, "strobes");
      chk(n_commit - c0, {31'h0, commit}, "commits");
      chk({31'h0, v[10]}, {31'h0, commit}, "stored flag");
      chk({29'h0, tones_seen}, {29'h0, exp_tones(three)}, "tones");
      chk({31'h0, three_tone}, {31'h0, three}, "three");
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   // four runs of about 3200 clock cycles each plus margin
   initial begin
      repeat (30000) @(posedge sys_clk);
      error_cnt++;
      give_verdict();
   end
   initial begin
      void'($urandom(99));
      repeat (16) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      axi_rd(`MCAS_H_HOLD, d, `MCAS_RESP_OK);
      chk(d, 32'h316, "hold reset");
      axi_rd(4'hC, d, `MCAS_RESP_ERR);
      chk(d, 32'h0, "unmapped data");
      axi_wr(4'hC, 32'h1, `MCAS_RESP_ERR);
      // go with its byte lane masked must not start the sequencer
      wstrb <= 4'h0;
      axi_wr(`MCAS_H_CTRL, 32'h1, `MCAS_RESP_OK);
      wstrb <= 4'hF;
      axi_rd(`MCAS_H_STAT, d, `MCAS_RESP_OK);
      chk(d, 32'h0, "masked go");
      // first run at the reset hold, the tightest stop timing
      run(1'b0, 1'b1, 1'b1);
      axi_wr(`MCAS_H_HOLD, 32'h320, `MCAS_RESP_OK);
      hold_ms = 800;
      run(1'b1, 1'b0, 1'b0);
      repeat (2) begin
         r = $urandom;
         run(r[0], r[1], r[2]);
      end
      give_verdict();
   end
endmodule // testbench
